// ### include/gpm_pkg.sv
// package for the gauge power mode sequencer: modes, timing, commands
package gpm_pkg;
   // clock rate and derived scale
   localparam longint GPM_CLK_HZ        = 100_000_000;
   // timing figures in their own units
   localparam longint GPM_LOW_QUAL_S    = 16;
   localparam longint GPM_NOACT_MAX_MIN = 30;
   localparam longint GPM_WAKE_H        = 4;
   localparam longint GPM_CHECK_MIN     = 15;
   // derived cycle counts (least times, whole cycles)
   localparam longint GPM_LOW_QUAL_CYC  = GPM_LOW_QUAL_S * GPM_CLK_HZ;
   localparam longint GPM_NOACT_CYC     = GPM_NOACT_MAX_MIN * 60 * GPM_CLK_HZ;
   localparam longint GPM_WAKE_CYC      = GPM_WAKE_H * 3600 * GPM_CLK_HZ;
   localparam longint GPM_CHECK_CYC     = GPM_CHECK_MIN * 60 * GPM_CLK_HZ;
   // extended activity check every this many wakeups
   localparam int     GPM_CHECK_EVERY   = 3;
   // fewer than this many integrator counts means idle when deadband is zero
   localparam int     GPM_ZERO_DB_CNT   = 2;
   // ship arming command on the wire
   localparam logic [7:0] GPM_CMD_WRITE_BIT = 8'h80;
   localparam logic [6:0] GPM_CTRL_ADDR     = 7'h00;
   localparam logic [7:0] GPM_SHIP_CMD      = 8'hA9;
   localparam int     GPM_CMD_WR_POS    = 7;

   typedef enum logic [2:0] {
      GPM_ACTIVE,
      GPM_SLEEP,
      GPM_WAKE_CONV,
      GPM_ACT_CHECK,
      GPM_SHIP,
      GPM_HIBERNATE
   } gpm_mode_t;

   // one decoded write from the wire engine
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
      logic [7:0] data;
   } gpm_wr_t;

   // per-mode enables presented to the rest of the gauge
   typedef struct packed {
      logic gauge_en;
      logic self_dis_en;
      logic temp_conv;
      logic ram_hold;
      logic halted;
   } gpm_ctl_t;
endpackage

// ### hw/gpm_timer.sv
// free restartable cycle timer with terminal flag
module gpm_timer
   import gpm_pkg::*;
#(
   parameter int     W     = 40,
   parameter longint LIMIT = 16
)
(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic restart,
   input  wire logic run,
   output logic      done
);
   logic [W-1:0] cnt_r;
   localparam logic [W-1:0] LIM = W'(LIMIT - 1);

   // count while run, saturate at LIMIT - 1; restart wins
   always_ff @(posedge clock)
   begin
      if (!nrst || restart)
         cnt_r <= '0;
      else if (run && cnt_r != LIM)
         cnt_r <= cnt_r + W'(1);
   end

   assign done = (cnt_r == LIM);
endmodule

// ### hw/gpm_sequencer.sv
// power mode sequencer: active, sleep, ship and hibernate control
// Contract
// - active mode runs full gauging
// - sleep after 16 s low and idle
// - idle decision may take 30 minutes
// - sleep keeps self-discharge at sleep temperature
// - wake each 4 h, convert, resleep
// - first wake holds 15 minute activity check
// - extended check every third wakeup
// - line high leaves sleep, requalify fully; the low time and the zero deadband window restart, the no-activity window does not
// - zero deadband: under 2 counts/15 min
// - ship after armed and 16 s low
// - transients do not block ship entry
// - ship halts; exit on line or POR
// - ship glitch returns active, disarms ship
// - hibernate under POR with backup present
// - hibernate keeps RAM contents
// - command MSB set means register write
module gpm_sequencer
   import gpm_pkg::*;
#(
   parameter longint LOW_QUAL_CYC = GPM_LOW_QUAL_CYC,
   parameter longint NOACT_CYC    = GPM_NOACT_CYC,
   parameter longint WAKE_CYC     = GPM_WAKE_CYC,
   parameter longint CHECK_CYC    = GPM_CHECK_CYC
)
(
   input  wire logic      clock,
   input  wire logic      nrst,
   input  wire logic      single_wire_host_line,
   input  wire logic      activity_above_deadband,
   input  wire logic      deadband_is_zero,
   input  wire logic      charge_integrator_tick,
   input  wire logic      supply_below_por,
   input  wire logic      backup_supply_pin,
   input  wire logic      ship_enable_bit,
   input  wire gpm_wr_t   wire_write,
   input  wire logic      temp_conv_done,
   output gpm_mode_t      mode,
   output gpm_ctl_t       ctl,
   output logic           ship_armed
);
   // pin synchronisers
   logic [1:0] line_s_r;
   logic [1:0] por_s_r;
   logic [1:0] rbi_s_r;
   logic       line_hi;
   logic       por_lo;
   logic       rbi_on;

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         line_s_r <= 2'b00;
         por_s_r  <= 2'b00;
         rbi_s_r  <= 2'b00;
      end
      else
      begin
         line_s_r <= {line_s_r[0], single_wire_host_line};
         por_s_r  <= {por_s_r[0], supply_below_por};
         rbi_s_r  <= {rbi_s_r[0], backup_supply_pin};
      end
   end
   assign line_hi = line_s_r[1];
   assign por_lo  = por_s_r[1];
   assign rbi_on  = rbi_s_r[1];

   gpm_mode_t mode_r;
   gpm_mode_t mode_nxt;
   logic      low_done;
   logic      noact_done;
   logic      wake_done;
   logic      check_done;
   logic      idle_zero_r;
   logic      act_seen_r;
   logic [1:0] zcnt_r;
   logic [1:0] wake_cnt_r;
   logic      ship_armed_r;
   logic      mode_chg;
   logic      ship_cmd;

   assign mode_chg = (mode_nxt != mode_r);

   // low-line qualification; any high sample restarts it
   gpm_timer #(.W(40), .LIMIT(LOW_QUAL_CYC)) u_low
   (
      .clock   (clock),
      .nrst    (nrst),
      .restart (line_hi || mode_chg),
      .run     (1'b1),
      .done    (low_done)
   );

   // no-activity window: restarted by any activity
   gpm_timer #(.W(40), .LIMIT(NOACT_CYC)) u_noact
   (
      .clock   (clock),
      .nrst    (nrst),
      .restart (activity_above_deadband),
      .run     (mode_r == GPM_ACTIVE),
      .done    (noact_done)
   );

   // sleep period before each temperature wakeup
   gpm_timer #(.W(48), .LIMIT(WAKE_CYC)) u_wake
   (
      .clock   (clock),
      .nrst    (nrst),
      .restart (mode_r != GPM_SLEEP),
      .run     (1'b1),
      .done    (wake_done)
   );

   // extended activity check window, also the zero deadband window
   gpm_timer #(.W(40), .LIMIT(CHECK_CYC)) u_check
   (
      .clock   (clock),
      .nrst    (nrst),
      .restart (mode_chg || (mode_r == GPM_ACTIVE && check_done)),
      .run     (1'b1),
      .done    (check_done)
   );

   // integrator counts per window when deadband is zero
   always_ff @(posedge clock)
   begin
      if (!nrst || mode_chg || check_done)
         zcnt_r <= 2'b00;
      else if (charge_integrator_tick && zcnt_r != 2'(GPM_ZERO_DB_CNT))
         zcnt_r <= zcnt_r + 2'b01;
   end

   // zero deadband idle verdict latched at each window end
   always_ff @(posedge clock)
   begin
      if (!nrst || mode_chg)
         idle_zero_r <= 1'b0;
      else if (check_done)
         idle_zero_r <= (zcnt_r < 2'(GPM_ZERO_DB_CNT));
   end

   // activity seen during the extended check
   always_ff @(posedge clock)
   begin
      if (!nrst || mode_chg)
         act_seen_r <= 1'b0;
      else if (activity_above_deadband)
         act_seen_r <= 1'b1;
   end

   // wakeups since last extended check; zero means check due
   always_ff @(posedge clock)
   begin
      if (!nrst || mode_r == GPM_ACTIVE)
         wake_cnt_r <= 2'b00;
      else if (mode_r == GPM_SLEEP && wake_done)
      begin
         if (wake_cnt_r == 2'(GPM_CHECK_EVERY - 1))
            wake_cnt_r <= 2'b00;
         else
            wake_cnt_r <= wake_cnt_r + 2'b01;
      end
   end

   // ship arming command; valid already stands for a write-flagged command
   assign ship_cmd = wire_write.valid
      && wire_write.addr == GPM_CTRL_ADDR
      && wire_write.data == GPM_SHIP_CMD;

   // arm flag; cleared on the edge that enters ship, so a glitch exit
   // from ship needs a fresh command before ship can be taken again
   always_ff @(posedge clock)
   begin
      if (!nrst)
         ship_armed_r <= 1'b0;
      else if (ship_cmd && ship_enable_bit)
         ship_armed_r <= 1'b1;
      else if (mode_nxt == GPM_SHIP)
         ship_armed_r <= 1'b0;
   end

   logic idle;
   // idle: deadband mode or zero-deadband count mode
   assign idle = deadband_is_zero ? idle_zero_r : noact_done;

   // mode transitions; supply loss with backup overrides all
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         GPM_ACTIVE:
         begin
            if (ship_armed_r && low_done)
               mode_nxt = GPM_SHIP;
            else if (low_done && idle && !ship_armed_r)
               mode_nxt = GPM_SLEEP;
         end
         GPM_SLEEP:
         begin
            if (line_hi)
               mode_nxt = GPM_ACTIVE;
            else if (wake_done)
               mode_nxt = (wake_cnt_r == 2'b00) ? GPM_ACT_CHECK
                                                 : GPM_WAKE_CONV;
         end
         GPM_WAKE_CONV:
         begin
            if (line_hi)
               mode_nxt = GPM_ACTIVE;
            else if (low_done && temp_conv_done)
               mode_nxt = GPM_SLEEP;
         end
         GPM_ACT_CHECK:
         begin
            if (line_hi)
               mode_nxt = GPM_ACTIVE;
            else if (check_done)
               mode_nxt = act_seen_r ? GPM_ACTIVE : GPM_SLEEP;
         end
         GPM_SHIP:
         begin
            if (line_hi)
               mode_nxt = GPM_ACTIVE;
         end
         GPM_HIBERNATE:
         begin
            if (!por_lo)
               mode_nxt = GPM_ACTIVE;
         end
         default:
            mode_nxt = GPM_ACTIVE;
      endcase
      if (por_lo && rbi_on)
         mode_nxt = GPM_HIBERNATE;
      else if (por_lo && mode_r == GPM_SHIP)
         mode_nxt = GPM_ACTIVE;
   end

   // mode register
   always_ff @(posedge clock)
   begin
      if (!nrst)
         mode_r <= GPM_ACTIVE;
      else
         mode_r <= mode_nxt;
   end

   // per-mode enables, registered
   always_ff @(posedge clock)
   begin
      if (!nrst)
         ctl <= '0;
      else
      begin
         ctl.gauge_en    <= (mode_nxt == GPM_ACTIVE
                             || mode_nxt == GPM_ACT_CHECK);
         ctl.self_dis_en <= (mode_nxt == GPM_SLEEP
                             || mode_nxt == GPM_WAKE_CONV);
         ctl.temp_conv   <= (mode_nxt == GPM_WAKE_CONV
                             || mode_nxt == GPM_ACT_CHECK);
         ctl.ram_hold    <= (mode_nxt == GPM_HIBERNATE);
         ctl.halted      <= (mode_nxt == GPM_SHIP
                             || mode_nxt == GPM_HIBERNATE);
      end
   end

   assign mode       = mode_r;
   assign ship_armed = ship_armed_r;
endmodule

// ### sim/gpm_chk.sv
// port checker for the power mode sequencer
module gpm_chk
   import gpm_pkg::*;
(
   input wire logic      clock,
   input wire logic      nrst,
   input wire logic      single_wire_host_line,
   input wire logic      supply_below_por,
   input wire logic      backup_supply_pin,
   input wire logic      ship_enable_bit,
   input wire gpm_wr_t   wire_write,
   input wire gpm_mode_t mode,
   input wire gpm_ctl_t  ctl,
   input wire logic      ship_armed
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // decoded ship command on the write port
   sequence ship_cmd_s;
      wire_write.valid && wire_write.addr == GPM_CTRL_ADDR
         && wire_write.data == GPM_SHIP_CMD;
   endsequence
   // line held high long enough to clear the synchroniser
   sequence line_high_s;
      single_wire_host_line [*4];
   endsequence
   a_arm_on_cmd: assert property (ship_cmd_s ##0 (ship_enable_bit
      && mode == GPM_ACTIVE && !ship_armed) |=> ship_armed)
      else $error("ship command did not arm");
   a_arm_refused: assert property (wire_write.valid && !ship_enable_bit
      && !ship_armed |=> !ship_armed)
      else $error("armed without enable bit");
   a_ship_needs_arm: assert property (mode == GPM_SHIP
      && $past(mode) != GPM_SHIP |-> $past(ship_armed))
      else $error("ship entered unarmed");
   a_sleep_unarmed: assert property (mode == GPM_SLEEP
      && $past(mode) == GPM_ACTIVE |-> !$past(ship_armed))
      else $error("sleep taken while armed");
   a_ship_halts: assert property (mode == GPM_SHIP |-> ctl.halted
      && !ctl.gauge_en && !ship_armed)
      else $error("ship not halted or still armed");
   a_line_wakes: assert property ((mode == GPM_SLEEP) ##0 line_high_s
      |=> mode != GPM_SLEEP)
      else $error("line high did not end sleep");
   a_hib_entry: assert property ((supply_below_por
      && backup_supply_pin) [*4] |=> mode == GPM_HIBERNATE)
      else $error("hibernate not entered");
   a_hib_ram: assert property (mode == GPM_HIBERNATE |-> ctl.ram_hold)
      else $error("hibernate without ram hold");
   a_active_gauge: assert property ($past(nrst) && mode == GPM_ACTIVE
      |-> ctl.gauge_en)
      else $error("active without gauging");
   a_sleep_selfdis: assert property (mode == GPM_SLEEP
      |-> ctl.self_dis_en && !ctl.gauge_en)
      else $error("sleep enables wrong");
endmodule
bind gpm_sequencer gpm_chk chk_u (.clock(clock), .nrst(nrst),
   .single_wire_host_line(single_wire_host_line),
   .supply_below_por(supply_below_por), .backup_supply_pin(backup_supply_pin),
   .ship_enable_bit(ship_enable_bit), .wire_write(wire_write), .mode(mode),
   .ctl(ctl), .ship_armed(ship_armed));

// ### sim/gpm_host.sv
// host model: line level, enable bit and decoded writes
module gpm_host
   import gpm_pkg::*;
(
   input  wire logic clock,
   output logic      line,
   output logic      ship_en,
   output gpm_wr_t   wr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      line = 1'b1;
      ship_en = 1'b0;
      wr = '0;
   end
   // enable bit first, then one write cycle, all on falling edges
   task automatic arm(input logic en, input logic [7:0] data);
      logic [7:0] cmd;
      cmd = GPM_CMD_WRITE_BIT | {1'b0, GPM_CTRL_ADDR};
      @(negedge clock);
      ship_en <= en;
      @(negedge clock);
      wr <= {cmd[GPM_CMD_WR_POS], cmd[6:0], data};
      @(negedge clock);
      wr <= '0;
   endtask
   task automatic drive(input logic lvl);
      @(negedge clock);
      line <= lvl;
   endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the power mode sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gpm_pkg::*;
   logic      clock, nrst, act, dbz, tick, por, bkp, tdone, line, ship_en;
   logic      armed;
   gpm_wr_t   wr;
   gpm_mode_t mode;
   gpm_ctl_t  ctl;
   int        n_mismatch = 0;
   int        n_compared = 0;
   int        w;
   gpm_mode_t exp_m;
   logic [7:0] rnd;
   gpm_sequencer #(.LOW_QUAL_CYC(20), .NOACT_CYC(50), .WAKE_CYC(100),
      .CHECK_CYC(40)) dut_u (.clock(clock), .nrst(nrst),
      .single_wire_host_line(line), .activity_above_deadband(act),
      .deadband_is_zero(dbz), .charge_integrator_tick(tick),
      .supply_below_por(por), .backup_supply_pin(bkp),
      .ship_enable_bit(ship_en), .wire_write(wr), .temp_conv_done(tdone),
      .mode(mode), .ctl(ctl), .ship_armed(armed));
   gpm_host host_u (.clock(clock), .line(line), .ship_en(ship_en), .wr(wr));
   always #5 clock = ~clock;
   // conversion finish comes at random; only wake conversion waits on it
   always @(negedge clock) tdone <= 1'($urandom_range(0, 1));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // bounded wait, then mode and earliest arrival compared
   task automatic wait_mode(input gpm_mode_t m, input int lo, input int hi);
      int n;
      n = 0;
      while (mode !== m && n < hi)
      begin
         @(negedge clock);
         n++;
      end
      check(16'(mode), 16'(m));
      check(16'(n >= lo), 16'h0001);
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial
   begin
      repeat (4000) @(posedge clock);
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      clock = 0;
      nrst = 0;
      act = 0;
      dbz = 0;
      tick = 0;
      por = 0;
      bkp = 0;
      void'($urandom(32'he3e5_b1cc));
      repeat (4) @(negedge clock);
      nrst = 1;
      repeat (2) @(negedge clock);
      check(16'(mode), 16'(GPM_ACTIVE));
      check(16'(ctl.gauge_en), 16'h0001);
      host_u.drive(1'b0);
      // random activity never leaves the idle window a full run
      repeat (150)
      begin
         act = 1'($urandom_range(0, 1));
         @(negedge clock);
      end
      check(16'(mode), 16'(GPM_ACTIVE));
      act = 1;
      @(negedge clock);
      act = 0;
      wait_mode(GPM_SLEEP, 50, 400);
      check(16'(ctl.self_dis_en), 16'h0001);
      host_u.drive(1'b1);
      wait_mode(GPM_ACTIVE, 0, 5);
      // refused arms: no enable bit, then a wrong data byte
      rnd = 8'($urandom_range(0, 255));
      if (rnd == GPM_SHIP_CMD)
         rnd = rnd ^ 8'h01;
      host_u.arm(1'b0, GPM_SHIP_CMD);
      check(16'(armed), 16'h0000);
      host_u.arm(1'($urandom_range(0, 1)), rnd);
      check(16'(armed), 16'h0000);
      host_u.arm(1'b1, GPM_SHIP_CMD);
      check(16'(armed), 16'h0001);
      host_u.drive(1'b0);
      repeat (10) @(negedge clock);
      // one-cycle high transient while armed must not cancel ship entry
      host_u.drive(1'b1);
      host_u.drive(1'b0);
      check(16'(armed), 16'h0001);
      wait_mode(GPM_SHIP, 20, 200);
      check(16'(armed), 16'h0000);
      check(16'(ctl.halted), 16'h0001);
      host_u.drive(1'b1);
      wait_mode(GPM_ACTIVE, 0, 5);
      host_u.drive(1'b0);
      wait_mode(GPM_SLEEP, 20, 400);
      // wakeups 1..4: first and every third one run the long check
      for (w = 1; w <= 4; w++)
      begin
         exp_m = (w % 3 == 1) ? GPM_ACT_CHECK : GPM_WAKE_CONV;
         wait_mode(exp_m, 0, 150);
         check(16'(ctl.temp_conv), 16'h0001);
         wait_mode(GPM_SLEEP, 0, 100);
      end
      por = 1;
      bkp = 1;
      wait_mode(GPM_HIBERNATE, 0, 6);
      check(16'(ctl.ram_hold), 16'h0001);
      por = 0;
      wait_mode(GPM_ACTIVE, 0, 6);
      // zero deadband: dense random integrator ticks keep it awake
      dbz = 1;
      repeat (150)
      begin
         tick = 1'($urandom_range(0, 1));
         @(negedge clock);
      end
      tick = 0;
      check(16'(mode), 16'(GPM_ACTIVE));
      wait_mode(GPM_SLEEP, 0, 300);
      give_verdict();
   end
endmodule
